// File: atp_pkg.sv
package atp_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned LOSS_TIME_NS = 10000;
  localparam int unsigned LOSS_CYC =
    (LOSS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [9:0] LOSS_CNT_MAX = 10'(LOSS_CYC - 1);

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_DELAY = 8'h08;

  // ----------------------------------------------------------------
  // Input formats and sample rates
  // ----------------------------------------------------------------
  localparam logic [2:0] FMT_STD = 3'h0;
  localparam logic [2:0] FMT_TDM4 = 3'h1;
  localparam logic [2:0] FMT_TDM8_D1 = 3'h2;
  localparam logic [2:0] FMT_TDM8_D2 = 3'h3;
  localparam logic [1:0] RATE_44K1 = 2'h0;
  localparam logic [1:0] RATE_48K = 2'h1;
  localparam logic [1:0] RATE_96K = 2'h2;
  localparam logic [1:0] RATE_192K = 2'h3;
  localparam logic [31:0] DELAY_44K1_US = 32'h0000_01E9;
  localparam logic [31:0] DELAY_48K_US = 32'h0000_01C2;
  localparam logic [31:0] DELAY_96K_US = 32'h0000_00BC;
  localparam logic [31:0] DELAY_192K_US = 32'h0000_0050;

  // ----------------------------------------------------------------
  // Frame geometry
  // ----------------------------------------------------------------
  localparam logic [4:0] WORD_LAST = 5'h17;
  localparam logic [8:0] LEN_STD = 9'h040;
  localparam logic [8:0] LEN_TDM4 = 9'h080;
  localparam logic [8:0] LEN_TDM8 = 9'h100;
  localparam logic [8:0] WSH_MIN = 9'h002;
  localparam logic [8:0] WSH_MAX_TDM4 = 9'h07F;
  localparam logic [8:0] WSH_MAX_TDM8 = 9'h0FF;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef logic [23:0] atp_word_t;
  typedef logic [3:0][23:0] atp_samp_t;

  typedef struct packed {
    logic [1:0] rate;
    logic dev_two;
    logic line13;
    logic tdm16;
    logic [2:0] input_format_control;
  } atp_cfg_t;

  typedef struct packed {
    logic [6:0] rsv_hi;
    logic [8:0] len;
    logic [11:0] rsv_lo;
    logic ws_err;
    logic len_err;
    logic lock;
    logic lost;
  } atp_stat_t;

  typedef struct packed {
    logic [8:0] len;
    logic len_err;
    logic ws_err;
  } atp_frame_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } atp_req_t;

  typedef struct packed {
    logic ana_mute;
    logic dig_mute;
    logic bias_hold;
    logic prot_keep;
    logic core_rst_n;
  } atp_safe_t;

  localparam atp_cfg_t CFG_RESET = atp_cfg_t'(8'h00);
  localparam atp_stat_t STAT_RESET = atp_stat_t'(32'h0000_0001);

endpackage : atp_pkg

// File: atp_sync.sv
`timescale 1ns/1ns

module atp_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Data
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } atp_sync_st_t;

  atp_sync_st_t st_q;
  atp_sync_st_t st_d;

  always_comb begin
    st_d.s1 = i_d;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_q = st_q.s2;

endmodule : atp_sync

// File: atp_port.sv
// The implementer's own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ns

// What this block does
// - The port is a slave only: bit clock and frame select are inputs.
// - In format 000, line ch1/ch3 feeds channels 1 and 3, line ch2/ch4 feeds 2 and 4.
// - On bit clock loss the block mutes, holds bias, keeps protection.
// - Every slot is 32 bit clocks and carries a 24-bit MSB-first word.
// - A frame is 64, 128 or 256 bit clocks for standard, TDM4, TDM8/16.
// - Format 000 decodes the standard two-channel format.
// - Format 001 takes four slots from line ch2/ch4 as channels 1 to 4.
// - Formats 010 and 011 share eight slots between two devices.
// - A config bit extends TDM8 to sixteen slots over both lines.
// - Both data lines and frame select are sampled on the rising edge.
// - Group delay of the first interpolator is reported per rate.
// - Without clock lock only analog mute applies and the core resets.
module atp_port (
  // System clock and reset
  input wire logic I_CLK,
  input wire logic I_RST_N,
  // Register port
  input wire atp_pkg::atp_req_t I_REQ,
  output logic [31:0] O_RDATA,
  // Serial audio link, all driven by the host
  input wire logic I_BIT_CLK,
  input wire logic I_FRAME_SEL,
  input wire logic I_SERIAL_IN_CH1_CH3,
  input wire logic I_SERIAL_IN_CH2_CH4,
  // Clock recovery lock
  input wire logic I_LOCK,
  // Samples toward the interpolator
  output atp_pkg::atp_samp_t O_SAMPLE,
  output logic O_SAMPLE_VALID,
  // Protection and mute
  output atp_pkg::atp_safe_t O_SAFE
);

  // ----------------------------------------------------------------
  // State types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic ws_last;
    logic half;
    logic started;
    logic [7:0] bcnt;
    logic [8:0] fcnt;
    logic [8:0] whigh;
    logic ws_bad;
    logic [22:0] sh13;
    logic [22:0] sh24;
    atp_pkg::atp_samp_t ch;
    atp_pkg::atp_samp_t hold;
    atp_pkg::atp_frame_t info;
    logic tgl;
    logic [1:0] div;
    atp_pkg::atp_cfg_t cfg_seen;
    atp_pkg::atp_cfg_t cfg;
  } atp_link_st_t;

  typedef struct packed {
    logic [9:0] wd;
    logic act_last;
    logic tgl_last;
    atp_pkg::atp_samp_t samp;
    logic valid;
    atp_pkg::atp_cfg_t cfg;
    atp_pkg::atp_stat_t stat;
    logic [31:0] rdata;
  } atp_sys_st_t;

  atp_link_st_t lnk_q;
  atp_link_st_t lnk_d;
  atp_sys_st_t sys_q;
  atp_sys_st_t sys_d;
  atp_pkg::atp_cfg_t lcfg;
  logic [2:0] sys_s;
  atp_pkg::atp_cfg_t cfg_s;
  logic sys_rst_n;
  logic lnk_rst_n;

  // ----------------------------------------------------------------
  // Crossings
  // ----------------------------------------------------------------
  // Config is quasi-static; software changes it only while idle
  atp_sync #(.W($bits(atp_pkg::atp_cfg_t))) u_cfg_sync (
    .i_clk(I_BIT_CLK),
    .i_rst_n(I_RST_N),
    .i_d(sys_q.cfg),
    .o_q(cfg_s)
  );

  // Word taken only after two equal samples, so a torn update never acts
  assign lcfg = lnk_q.cfg;

  // Reset asserts at once but releases on each domain's own clock
  atp_sync #(.W(1)) u_sys_rst (
    .i_clk(I_CLK),
    .i_rst_n(I_RST_N),
    .i_d(1'b1),
    .o_q(sys_rst_n)
  );

  // Stopped bit clock keeps the link in reset; harmless, it has no edges
  atp_sync #(.W(1)) u_lnk_rst (
    .i_clk(I_BIT_CLK),
    .i_rst_n(I_RST_N),
    .i_d(1'b1),
    .o_q(lnk_rst_n)
  );

  atp_sync #(.W(3)) u_sys_sync (
    .i_clk(I_CLK),
    .i_rst_n(I_RST_N),
    .i_d({lnk_q.tgl, lnk_q.div[1], I_LOCK}),
    .o_q(sys_s)
  );

  // ----------------------------------------------------------------
  // Link domain, on the host's bit clock
  // ----------------------------------------------------------------
  always_comb begin
    atp_pkg::atp_word_t w13;
    atp_pkg::atp_word_t w24;
    atp_pkg::atp_word_t wsel;
    logic [2:0] slot;
    logic [4:0] bpos;
    logic is_std;
    logic is_tdm8;
    logic fr_start;
    logic half_chg;
    logic mine;
    logic [8:0] wmax;
    logic [8:0] lexp;
    logic [8:0] flen;
    w13 = {lnk_q.sh13, I_SERIAL_IN_CH1_CH3};
    w24 = {lnk_q.sh24, I_SERIAL_IN_CH2_CH4};
    is_std = lcfg.input_format_control == atp_pkg::FMT_STD;
    is_tdm8 = lcfg.input_format_control[1];
    wsel = (is_tdm8 && lcfg.tdm16 && lcfg.line13) ? w13 : w24;
    slot = is_std ? {2'h0, lnk_q.half} : lnk_q.bcnt[7:5];
    bpos = lnk_q.bcnt[4:0];
    // Standard frame opens on select fall, TDM on select rise
    fr_start = is_std ? (lnk_q.ws_last && !I_FRAME_SEL)
                      : (!lnk_q.ws_last && I_FRAME_SEL);
    half_chg = is_std && (lnk_q.ws_last != I_FRAME_SEL);
    // Group order: device one first unless format 011 flips it
    mine = slot[2] == ((lcfg.input_format_control ==
                        atp_pkg::FMT_TDM8_D2) ^ lcfg.dev_two);
    wmax = is_tdm8 ? atp_pkg::WSH_MAX_TDM8 : atp_pkg::WSH_MAX_TDM4;
    lexp = is_std ? atp_pkg::LEN_STD
         : (is_tdm8 ? atp_pkg::LEN_TDM8 : atp_pkg::LEN_TDM4);
    flen = (lnk_q.fcnt == 9'h1FF) ? lnk_q.fcnt : lnk_q.fcnt + 9'h001;
    lnk_d = lnk_q;
    lnk_d.ws_last = I_FRAME_SEL;
    lnk_d.div = lnk_q.div + 2'h1;
    lnk_d.fcnt = flen;
    // Config settles two bit clocks later than the raw synchroniser
    lnk_d.cfg_seen = cfg_s;
    if (cfg_s == lnk_q.cfg_seen) begin
      lnk_d.cfg = cfg_s;
    end
    // Shift the word bits; slot bits past the word are padding
    if (bpos <= atp_pkg::WORD_LAST) begin
      lnk_d.sh13 = w13[22:0];
      lnk_d.sh24 = w24[22:0];
    end
    if (bpos == atp_pkg::WORD_LAST && lnk_q.started) begin
      unique case (lcfg.input_format_control)
        atp_pkg::FMT_STD: begin
          lnk_d.ch[{slot[0], 1'b0}] = w13;
          lnk_d.ch[{slot[0], 1'b1}] = w24;
        end
        atp_pkg::FMT_TDM4: begin
          if (!slot[2]) begin
            lnk_d.ch[slot[1:0]] = w24;
          end
        end
        atp_pkg::FMT_TDM8_D1, atp_pkg::FMT_TDM8_D2: begin
          if (mine) begin
            lnk_d.ch[slot[1:0]] = wsel;
          end
        end
        default: begin
        end
      endcase
    end
    // Select high width check, TDM only; asymmetric pulses are fine
    if (I_FRAME_SEL) begin
      if (!lnk_q.ws_last) begin
        lnk_d.whigh = 9'h001;
      end else if (lnk_q.whigh != 9'h1FF) begin
        lnk_d.whigh = lnk_q.whigh + 9'h001;
      end
    end
    if (!is_std && lnk_q.ws_last && !I_FRAME_SEL) begin
      if (lnk_q.whigh < atp_pkg::WSH_MIN || lnk_q.whigh > wmax) begin
        lnk_d.ws_bad = 1'b1;
      end
    end
    if (fr_start || half_chg) begin
      lnk_d.bcnt = 8'h00;
      lnk_d.half = I_FRAME_SEL;
    end else begin
      lnk_d.bcnt = lnk_q.bcnt + 8'h01;
    end
    // Publish the finished frame to the system side
    if (fr_start) begin
      lnk_d.fcnt = 9'h000;
      lnk_d.started = 1'b1;
      lnk_d.ws_bad = 1'b0;
      if (lnk_q.started) begin
        lnk_d.hold = lnk_q.ch;
        lnk_d.info.len = flen;
        lnk_d.info.len_err = flen != lexp;
        lnk_d.info.ws_err = lnk_q.ws_bad;
        lnk_d.tgl = !lnk_q.tgl;
      end
    end
  end

  // Reset may release with the bit clock stopped; state then waits
  always_ff @(posedge I_BIT_CLK or negedge lnk_rst_n) begin
    if (!lnk_rst_n) begin
      lnk_q <= '0;
    end else begin
      lnk_q <= lnk_d;
    end
  end

  // ----------------------------------------------------------------
  // System domain: watchdog, sample handoff, registers
  // ----------------------------------------------------------------
  always_comb begin
    atp_pkg::atp_cfg_t wcfg;
    atp_pkg::atp_stat_t wstat;
    logic act;
    logic tgl;
    logic lock;
    logic wr_cfg;
    logic wr_stat;
    act = sys_s[1];
    tgl = sys_s[2];
    lock = sys_s[0];
    wcfg = atp_pkg::atp_cfg_t'(I_REQ.wdata[7:0]);
    wstat = atp_pkg::atp_stat_t'(I_REQ.wdata);
    wr_cfg = I_REQ.wr && I_REQ.addr == atp_pkg::ADDR_CONFIG;
    wr_stat = I_REQ.wr && I_REQ.addr == atp_pkg::ADDR_STATUS;
    sys_d = sys_q;
    sys_d.valid = 1'b0;
    sys_d.act_last = act;
    sys_d.stat.lock = lock;
    // Clock activity watchdog
    if (act != sys_q.act_last) begin
      sys_d.wd = 10'h000;
      sys_d.stat.lost = 1'b0;
    end else if (sys_q.wd == atp_pkg::LOSS_CNT_MAX) begin
      sys_d.stat.lost = 1'b1;
    end else begin
      sys_d.wd = sys_q.wd + 10'h001;
    end
    // Sticky errors: write one clears, a new event wins
    if (wr_stat && wstat.ws_err) begin
      sys_d.stat.ws_err = 1'b0;
    end
    if (wr_stat && wstat.len_err) begin
      sys_d.stat.len_err = 1'b0;
    end
    // Hold words are stable for a whole frame after the toggle
    if (tgl != sys_q.tgl_last) begin
      sys_d.tgl_last = tgl;
      sys_d.samp = lnk_q.hold;
      sys_d.valid = !sys_q.stat.lost;
      sys_d.stat.len = lnk_q.info.len;
      if (lnk_q.info.len_err) begin
        sys_d.stat.len_err = 1'b1;
      end
      if (lnk_q.info.ws_err) begin
        sys_d.stat.ws_err = 1'b1;
      end
    end
    if (sys_q.stat.lost) begin
      sys_d.samp = '0;
    end
    if (wr_cfg) begin
      sys_d.cfg.rate = wcfg.rate;
      sys_d.cfg.dev_two = wcfg.dev_two;
      sys_d.cfg.line13 = wcfg.line13;
      sys_d.cfg.tdm16 = wcfg.tdm16;
      if (!wcfg.input_format_control[2]) begin
        sys_d.cfg.input_format_control = wcfg.input_format_control;
      end
    end
    sys_d.rdata = 32'h0000_0000;
    if (I_REQ.rd) begin
      unique case (I_REQ.addr)
        atp_pkg::ADDR_CONFIG: begin
          sys_d.rdata = {24'h00_0000, sys_q.cfg};
        end
        atp_pkg::ADDR_STATUS: begin
          sys_d.rdata = sys_q.stat;
        end
        atp_pkg::ADDR_DELAY: begin
          unique case (sys_q.cfg.rate)
            atp_pkg::RATE_44K1: sys_d.rdata = atp_pkg::DELAY_44K1_US;
            atp_pkg::RATE_48K: sys_d.rdata = atp_pkg::DELAY_48K_US;
            atp_pkg::RATE_96K: sys_d.rdata = atp_pkg::DELAY_96K_US;
            atp_pkg::RATE_192K: sys_d.rdata = atp_pkg::DELAY_192K_US;
          endcase
        end
        default: begin
          sys_d.rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge I_CLK or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      sys_q <= '0;
      sys_q.cfg <= atp_pkg::CFG_RESET;
      sys_q.stat <= atp_pkg::STAT_RESET;
    end else begin
      sys_q <= sys_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // No clock or select is ever driven out; the host owns both
  assign O_RDATA = sys_q.rdata;
  assign O_SAMPLE = sys_q.samp;
  assign O_SAMPLE_VALID = sys_q.valid;
  // Digital mute needs lock; without it only analog mute acts
  assign O_SAFE.ana_mute = sys_q.stat.lost || !sys_q.stat.lock;
  assign O_SAFE.dig_mute = sys_q.stat.lost && sys_q.stat.lock;
  assign O_SAFE.bias_hold = sys_q.stat.lost;
  assign O_SAFE.prot_keep = 1'b1;
  assign O_SAFE.core_rst_n = sys_q.stat.lock;

endmodule : atp_port

// File: atp_port_monitor.sv
`timescale 1ns/1ns

module atp_port_monitor (
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_RST_N,
  // Register port
  input wire atp_pkg::atp_req_t I_REQ,
  input wire logic [31:0] O_RDATA,
  // Link and lock
  input wire logic I_BIT_CLK,
  input wire logic I_LOCK,
  // Samples and safety
  input wire atp_pkg::atp_samp_t O_SAMPLE,
  input wire logic O_SAMPLE_VALID,
  input wire atp_pkg::atp_safe_t O_SAFE
);
  // ----
  // Bit clock idle counter
  // ----
  logic bc_q;
  logic [9:0] idle_q;

  // Margin over the watchdog covers the synchroniser stages
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      bc_q <= 1'b0;
      idle_q <= 10'h000;
    end else begin
      bc_q <= I_BIT_CLK;
      if (I_BIT_CLK != bc_q) begin
        idle_q <= 10'h000;
      end else if (idle_q != 10'h3FF) begin
        idle_q <= idle_q + 10'h001;
      end
    end
  end

  // ----
  // Properties
  // ----
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_RST_N);

  property p_prot;
    O_SAFE.prot_keep;
  endproperty
  a_prot: assert property (p_prot)
    else $error("protection keep dropped");
  property p_lost_mute;
    O_SAFE.bias_hold |-> O_SAFE.ana_mute;
  endproperty
  a_lost_mute: assert property (p_lost_mute)
    else $error("clock loss without mute");
  property p_dig;
    O_SAFE.dig_mute |-> O_SAFE.bias_hold && O_SAFE.core_rst_n;
  endproperty
  a_dig: assert property (p_dig)
    else $error("digital mute without lock");
  property p_unlock;
    !O_SAFE.core_rst_n |-> O_SAFE.ana_mute && !O_SAFE.dig_mute;
  endproperty
  a_unlock: assert property (p_unlock)
    else $error("unlock mute wrong");
  property p_zero;
    O_SAFE.bias_hold && $past(O_SAFE.bias_hold)
      |-> O_SAMPLE == '0 && !O_SAMPLE_VALID;
  endproperty
  a_zero: assert property (p_zero)
    else $error("samples pass while clock lost");
  property p_pulse;
    O_SAMPLE_VALID |=> !O_SAMPLE_VALID;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("sample valid longer than one cycle");
  property p_delay;
    $past(I_REQ.rd) && $past(I_REQ.addr) == 8'h08
      |-> O_RDATA inside {32'h1E9, 32'h1C2, 32'hBC, 32'h50};
  endproperty
  a_delay: assert property (p_delay)
    else $error("group delay value wrong");
  property p_stop;
    idle_q == 10'h230 |-> O_SAFE.bias_hold;
  endproperty
  a_stop: assert property (p_stop)
    else $error("stopped bit clock not detected");
  property p_lockfall;
    $fell(I_LOCK) |-> ##[1:4] !O_SAFE.core_rst_n;
  endproperty
  a_lockfall: assert property (p_lockfall)
    else $error("core not reset on unlock");

  c_valid: cover property (O_SAMPLE_VALID);
  c_loss: cover property ($rose(O_SAFE.bias_hold));
  c_unlock: cover property ($fell(O_SAFE.core_rst_n));
endmodule : atp_port_monitor

bind atp_port atp_port_monitor u_mon (.I_CLK, .I_RST_N, .I_REQ, .O_RDATA,
  .I_BIT_CLK, .I_LOCK, .O_SAMPLE, .O_SAMPLE_VALID, .O_SAFE);

// File: atp_host_model.sv
`timescale 1ns/1ns

module atp_host_model (
  // Control
  input wire logic i_run,
  input wire logic i_std,
  input wire logic i_slow,
  input wire logic [8:0] i_len,
  input wire logic [8:0] i_wsh,
  input wire logic [7:0][23:0] i_a,
  input wire logic [7:0][23:0] i_b,
  // Serial link
  output logic o_bclk,
  output logic o_fs,
  output logic o_sd_a,
  output logic o_sd_b,
  output logic o_busy
);
  // ----
  // Frame generator
  // ----
  int n;
  int q;
  int h;

  // Clock stands still between runs; pad bits toggle so stale data shows
  initial begin
    o_bclk = 1'b0;
    o_fs = 1'b0;
    o_sd_a = 1'b0;
    o_sd_b = 1'b1;
    o_busy = 1'b0;
    forever begin
      wait (i_run === 1'b1);
      o_busy = 1'b1;
      while (i_run === 1'b1) begin
        n = int'(i_len);
        h = i_slow ? 48 : 32;
        for (int p = 0; p < n; p++) begin
          q = (p + n - 1) % n;
          o_fs = i_std ? (p >= 32) : (p < int'(i_wsh));
          if (q % 32 < 24) begin
            o_sd_a = i_a[q / 32][23 - q % 32];
            o_sd_b = i_b[q / 32][23 - q % 32];
          end else begin
            o_sd_a = ~o_sd_a;
            o_sd_b = ~o_sd_b;
          end
          #h o_bclk = 1'b1;
          #h o_bclk = 1'b0;
        end
      end
      o_sd_a = ~o_sd_a;
      o_sd_b = ~o_sd_b;
      o_busy = 1'b0;
    end
  end
endmodule : atp_host_model

// File: tb.sv
`timescale 1ns/1ns

module tb;
  // ----
  // Bench state
  // ----
  logic clk, rst_n, lock, valid, bclk, fs, sd_a, sd_b, busy;
  logic run, std, slow;
  logic [8:0] len, wsh;
  logic [7:0][23:0] wa, wb;
  logic [31:0] rdata;
  atp_pkg::atp_req_t req;
  atp_pkg::atp_samp_t samp;
  atp_pkg::atp_safe_t safe;
  int n_errors = 0;
  int compares = 0;
  int cyc = 0;

  atp_port uut (.I_CLK(clk), .I_RST_N(rst_n), .I_REQ(req), .O_RDATA(rdata),
    .I_BIT_CLK(bclk), .I_FRAME_SEL(fs), .I_SERIAL_IN_CH1_CH3(sd_a),
    .I_SERIAL_IN_CH2_CH4(sd_b), .I_LOCK(lock), .O_SAMPLE(samp),
    .O_SAMPLE_VALID(valid), .O_SAFE(safe));
  atp_host_model host (.i_run(run), .i_std(std), .i_slow(slow), .i_len(len),
    .i_wsh(wsh), .i_a(wa), .i_b(wb), .o_bclk(bclk), .o_fs(fs),
    .o_sd_a(sd_a), .o_sd_b(sd_b), .o_busy(busy));

  // ----
  // Shared tasks
  // ----
  task automatic give_verdict;
    if (n_errors == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict

  task automatic cmp(input string nm, input logic [31:0] e, g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask : cmp

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    req <= '0;
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a, output logic [31:0] g);
    @(posedge clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge clk);
    req <= '0;
    #1 g = rdata;
  endtask : reg_rd

  // Config only changes while the link is idle; sticky errors from the
  // restart frame are cleared before the judged frame
  task automatic play(input logic [7:0] c, input logic s,
                      input logic [8:0] l, input logic [8:0] w);
    logic [31:0] g;
    int nv;
    nv = 0;
    while (busy === 1'b1) @(posedge clk);
    reg_wr(8'h00, {24'h0, c});
    @(posedge clk);
    std <= s;
    len <= l;
    wsh <= w;
    run <= 1'b1;
    while (nv < 4) begin
      @(negedge clk);
      if (valid === 1'b1) nv++;
      if (nv == 3 && valid === 1'b1) reg_wr(8'h04, 32'h0000_000C);
    end
    reg_rd(8'h04, g);
    cmp("status", {7'h00, l, 12'h000, 4'h2}, g);
    @(posedge clk);
    run <= 1'b0;
  endtask : play

  task automatic chk4(input atp_pkg::atp_samp_t e);
    for (int k = 0; k < 4; k++) begin
      cmp($sformatf("channel %0d", k + 1), {8'h00, e[k]}, {8'h00, samp[k]});
    end
  endtask : chk4

  // ----
  // Scenarios
  // ----
  task automatic t_reset;
    logic [31:0] g;
    logic [3:0][31:0] dl;
    dl = {32'h0000_0050, 32'h0000_00BC, 32'h0000_01C2, 32'h0000_01E9};
    repeat (4) @(posedge clk);
    reg_wr(8'h0C, 32'hFFFF_FFFF);
    reg_rd(8'h0C, g);
    cmp("unmapped", 32'h0, g);
    reg_rd(8'h00, g);
    cmp("config", 32'h0, g);
    reg_rd(8'h04, g);
    cmp("status", 32'h3, g);
    for (int r = 0; r < 4; r++) begin
      reg_wr(8'h00, {24'h0, 2'(r), 6'h00});
      reg_rd(8'h08, g);
      cmp("delay", dl[r], g);
    end
  endtask : t_reset

  task automatic t_tdm8;
    int gr;
    for (int f = 2; f < 4; f++) begin
      for (int d = 0; d < 2; d++) begin
        gr = 4 * ((f == 3) ^ d);
        play({2'h0, 1'(d), 2'h0, 3'(f)}, 1'b0, 9'h100, 9'h0FF);
        chk4({wb[gr + 3], wb[gr + 2], wb[gr + 1], wb[gr]});
      end
    end
  endtask : t_tdm8

  task automatic t_reserved;
    logic [31:0] g;
    reg_wr(8'h00, 32'h0000_001C);
    reg_rd(8'h00, g);
    cmp("config", 32'h0000_0019, g);
    play(8'h1C, 1'b0, 9'h080, 9'h040);
    chk4({wb[3], wb[2], wb[1], wb[0]});
  endtask : t_reserved

  task automatic t_loss;
    logic [31:0] g;
    while (busy === 1'b1) @(posedge clk);
    repeat (700) @(negedge clk);
    cmp("safe", 32'h1F, {27'h0, safe});
    cmp("samples", 32'h0, {31'h0, samp != '0});
    reg_rd(8'h04, g);
    cmp("status", 32'h3, {28'h0, g[3:0]});
    lock <= 1'b0;
    repeat (8) @(negedge clk);
    cmp("safe", 32'h16, {27'h0, safe});
    @(posedge clk);
    lock <= 1'b1;
    repeat (8) @(posedge clk);
  endtask : t_loss

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      n_errors++;
      give_verdict;
    end
  end

  initial begin
    rst_n = 1'b0;
    lock = 1'b1;
    req = '0;
    run = 1'b0;
    std = 1'b0;
    slow = 1'b0;
    len = 9'h040;
    wsh = 9'h020;
    for (int i = 0; i < 8; i++) begin
      wa[i] = {4'hA, 4'(i), 16'h5C39};
      wb[i] = {4'h6, 4'(i), 16'hC3A5};
    end
    repeat (8) @(posedge clk);
    cmp("safe", 32'h16, {27'h0, safe});
    rst_n <= 1'b1;
    t_reset;
    play(8'h00, 1'b1, 9'h040, 9'h020);
    chk4({wb[1], wa[1], wb[0], wa[0]});
    slow <= 1'b1;
    play(8'h01, 1'b0, 9'h080, 9'h002);
    chk4({wb[3], wb[2], wb[1], wb[0]});
    slow <= 1'b0;
    t_reserved;
    t_tdm8;
    play(8'h3A, 1'b0, 9'h100, 9'h0FF);
    chk4({wa[7], wa[6], wa[5], wa[4]});
    t_loss;
    give_verdict;
  end
endmodule : tb
